// File: hdl/acg_host.sv
// host end: wishbone-controlled sequencer driving the cpu i/o bus
`timescale 1ns/1ns
module acg_host (
    input  wire logic        core_clk,  // system clock
    input  wire logic        srst,      // sync reset
    input  wire logic        wb_cyc_i,  // wishbone cycle
    input  wire logic        wb_stb_i,  // wishbone strobe
    input  wire logic        wb_we_i,   // wishbone write
    input  wire logic [7:0]  wb_adr_i,  // byte address
    input  wire logic [3:0]  wb_sel_i,  // byte lanes
    input  wire logic [31:0] wb_dat_i,  // write data
    output logic [31:0]      wb_dat_o,  // read data
    output logic             wb_ack_o,  // acknowledge
    acg_io_if.host           io         // cpu i/o bus
);
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ACC  = 8'h02,
        ST_GAP  = 8'h04,
        ST_WAIT = 8'h08,
        ST_POLL = 8'h10,
        ST_IRQW = 8'h20,
        ST_DONE = 8'h40
    } acg_hst_t;

    acg_hst_t    state_reg;
    acg_hst_t    ret_reg;
    logic [2:0]  scheme_reg;
    logic [2:0]  chan_reg;
    logic        second_reg;
    logic [9:0]  cnt_reg;
    logic [7:0]  addr_reg;
    logic [7:0]  wdata_reg;
    logic        is_wr_reg;
    logic [7:0]  cap_reg;
    logic [7:0]  result_reg;
    logic        done_reg;
    logic        ack_reg;
    logic        wb_req;
    logic        go;
    logic        strobe;
    logic        partial;
    logic [7:0]  port_addr;
    logic [2:0]  go_chan;
    logic [2:0]  go_scheme;

    // wishbone single-cycle slave, answers one cycle after the request
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign go     = wb_req & wb_we_i & (wb_adr_i == acg_pkg::ACG_REG_CTRL) & wb_sel_i[0]
                    & wb_dat_i[acg_pkg::ACG_CTRL_GO] & (state_reg == ST_IDLE);
    assign partial = (scheme_reg == acg_pkg::ACG_PARTIAL);
    assign port_addr = (scheme_reg == acg_pkg::ACG_UNDEC_ADDR)
                       ? (acg_pkg::ACG_UNDEC_CHBASE | {5'h00, chan_reg})
                       : acg_pkg::ACG_UNDEC_PORT;
    // go loads scheme and channel on the same edge, so the first access uses the write data
    assign go_chan   = wb_dat_i[acg_pkg::ACG_CTRL_CHAN +: 3];
    assign go_scheme = wb_dat_i[acg_pkg::ACG_CTRL_SCHEME +: 3];

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ack_reg    <= 1'b0;
            scheme_reg <= acg_pkg::ACG_CTRL_RST;
            chan_reg   <= 3'h0;
        end
        else
        begin
            ack_reg <= wb_req;
            if (wb_req & wb_we_i & (wb_adr_i == acg_pkg::ACG_REG_CTRL) & wb_sel_i[0]
                & (state_reg == ST_IDLE))
            begin
                scheme_reg <= wb_dat_i[acg_pkg::ACG_CTRL_SCHEME +: 3];
                chan_reg   <= wb_dat_i[acg_pkg::ACG_CTRL_CHAN +: 3];
            end
        end
    end

    // read mux
    always_ff @(posedge core_clk)
    begin
        if (srst)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_req & ~wb_we_i & (wb_adr_i == acg_pkg::ACG_REG_CTRL))
            wb_dat_o <= {25'h0, chan_reg, scheme_reg, 1'b0};
        else if (wb_req & ~wb_we_i & (wb_adr_i == acg_pkg::ACG_REG_STATUS))
            wb_dat_o <= {16'h0, result_reg, 6'h0, done_reg, state_reg != ST_IDLE};
        else
            wb_dat_o <= 32'h0000_0000;
    end

    assign wb_ack_o = ack_reg;

    // done flag: set by sequencer beats clear-by-write
    always_ff @(posedge core_clk)
    begin
        if (srst)
            done_reg <= 1'b0;
        else if (state_reg == ST_DONE)
            done_reg <= 1'b1;
        else if (wb_req & wb_we_i & (wb_adr_i == acg_pkg::ACG_REG_STATUS) & wb_sel_i[0]
                 & wb_dat_i[acg_pkg::ACG_ST_DONE])
            done_reg <= 1'b0;
    end

    // conversion sequencer; ST_ACC runs one bus access then returns to ret_reg
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_reg  <= ST_IDLE;
            ret_reg    <= ST_IDLE;
            cnt_reg    <= 10'h000;
            addr_reg   <= 8'hFF;
            wdata_reg  <= 8'h00;
            is_wr_reg  <= 1'b0;
            cap_reg    <= 8'h00;
            result_reg <= 8'h00;
            second_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 10'h001;
            case (state_reg)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        cnt_reg    <= 10'h000;
                        is_wr_reg  <= 1'b1;
                        second_reg <= 1'b0;
                        ret_reg    <= ST_GAP;
                        state_reg  <= ST_ACC;
                        if (go_scheme == acg_pkg::ACG_PARTIAL)
                            addr_reg <= acg_pkg::ACG_PD_ALE_BASE | {5'h00, go_chan};
                        else if (go_scheme == acg_pkg::ACG_UNDEC_ADDR)
                            addr_reg <= acg_pkg::ACG_UNDEC_CHBASE | {5'h00, go_chan};
                        else
                            addr_reg <= acg_pkg::ACG_UNDEC_PORT;
                        wdata_reg <= {5'h00, go_chan};
                    end
                end
                ST_ACC:
                begin
                    if (cnt_reg == 10'(acg_pkg::ACG_STROBE_CYC - 1))
                        cap_reg <= io.bus_rd;
                    if (cnt_reg == 10'(acg_pkg::ACG_STROBE_CYC))
                    begin
                        cnt_reg   <= 10'h000;
                        state_reg <= ret_reg;
                    end
                end
                ST_GAP:
                begin
                    // latch-to-start gap over 3 us, or settle before repeat
                    if (cnt_reg == 10'(acg_pkg::ACG_GAP_CYC))
                    begin
                        cnt_reg   <= 10'h000;
                        state_reg <= ST_ACC;
                        ret_reg   <= ST_WAIT;
                        if (partial)
                            addr_reg <= acg_pkg::ACG_PD_START;
                        // else same load-and-start written again
                        second_reg <= 1'b1;
                    end
                end
                ST_WAIT:
                begin
                    // let done fall before looking at it
                    if (cnt_reg == 10'(acg_pkg::ACG_EOC_WAIT_CYC))
                    begin
                        cnt_reg <= 10'h000;
                        if (partial)
                        begin
                            addr_reg  <= acg_pkg::ACG_PD_STATUS;
                            is_wr_reg <= 1'b0;
                            ret_reg   <= ST_POLL;
                            state_reg <= ST_ACC;
                        end
                        else
                        begin
                            state_reg <= ST_IRQW;
                        end
                    end
                end
                ST_POLL:
                begin
                    cnt_reg   <= 10'h000;
                    state_reg <= ST_ACC;
                    if (~cap_reg[0])
                    begin
                        addr_reg <= acg_pkg::ACG_PD_START;
                        ret_reg  <= ST_DONE;
                    end
                end
                ST_IRQW:
                begin
                    if (~io.irq_n)
                    begin
                        cnt_reg   <= 10'h000;
                        addr_reg  <= port_addr;
                        is_wr_reg <= 1'b0;
                        ret_reg   <= ST_DONE;
                        state_reg <= ST_ACC;
                    end
                end
                ST_DONE:
                begin
                    result_reg <= cap_reg;
                    state_reg  <= ST_IDLE;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // strobe low for the first cycles of an access, then one idle cycle
    assign strobe = (state_reg == ST_ACC) & (cnt_reg < 10'(acg_pkg::ACG_STROBE_CYC));
    assign io.io_write_strobe_n = ~(strobe & is_wr_reg);
    assign io.io_read_strobe_n  = ~(strobe & ~is_wr_reg);
    assign io.addr  = addr_reg;
    assign io.wdata = wdata_reg;
endmodule : acg_host

// File: hdl/acg_pkg.sv
// constants and types shared by both ends of the converter port glue
package acg_pkg;
    // decode schemes
    typedef enum logic [2:0] {
        ACG_UNDEC_DATA = 3'h1,
        ACG_UNDEC_ADDR = 3'h2,
        ACG_PARTIAL    = 3'h4
    } acg_scheme_t;

    localparam int          ACG_UNDEC_LINE   = 7;           // converter port address line
    localparam logic [1:0]  ACG_TOP_START    = 2'h0;        // top bits of start/data port
    localparam logic [1:0]  ACG_TOP_ALE      = 2'h1;        // top bits of latch/status port
    localparam logic [7:0]  ACG_UNDEC_PORT   = 8'h7F;       // single converter port
    localparam logic [7:0]  ACG_UNDEC_CHBASE = 8'h78;       // address-wired channel base
    localparam logic [7:0]  ACG_PD_ALE_BASE  = 8'h40;       // partial decode latch base
    localparam logic [7:0]  ACG_PD_START     = 8'h00;       // partial decode start/data
    localparam logic [7:0]  ACG_PD_STATUS    = 8'h40;       // partial decode status

    // timing
    localparam int ACG_CORE_HZ      = 50_000_000;
    localparam int ACG_CONV_HZ      = 640_000;
    localparam int ACG_CONV_HALF    = ACG_CORE_HZ / (2 * ACG_CONV_HZ);
    localparam int ACG_GAP_NS       = 3000;
    localparam int ACG_GAP_CYC      = (ACG_GAP_NS * (ACG_CORE_HZ / 1_000_000) + 999) / 1000 + 1;
    localparam int ACG_EOC_WAIT_CYC = 8 * 2 * ACG_CONV_HALF;
    localparam int ACG_STROBE_CYC   = 10;           // covers oe, pin sync and read register

    // host wishbone registers
    localparam logic [7:0] ACG_REG_CTRL   = 8'h00;
    localparam logic [7:0] ACG_REG_STATUS = 8'h04;
    localparam int ACG_CTRL_GO     = 0;
    localparam int ACG_CTRL_SCHEME = 1;  // bits 3:1
    localparam int ACG_CTRL_CHAN   = 4;  // bits 6:4
    localparam int ACG_ST_BUSY     = 0;
    localparam int ACG_ST_DONE     = 1;
    localparam int ACG_ST_RESULT   = 8;  // bits 15:8
    localparam logic [2:0] ACG_CTRL_RST = 3'h1;
endpackage : acg_pkg

// File: hdl/acg_io_if.sv
// cpu i/o bus between the host end and the converter glue
`timescale 1ns/1ns
interface acg_io_if;
    logic [7:0] addr;       // i/o address
    logic [7:0] wdata;      // host write data
    logic [7:0] rdata;      // glue read data
    logic [7:0] rdata_oe;   // glue drives bit when high
    logic [7:0] bus_rd;     // resolved bus, pulled high
    logic       io_write_strobe_n;
    logic       io_read_strobe_n;
    logic       irq_n_o;    // open-drain interrupt data
    logic       irq_n_oe;   // glue pulls line when high
    logic       irq_n;      // resolved interrupt line

    // resolve pulled-up lines
    assign bus_rd = (rdata & rdata_oe) | ~rdata_oe;
    assign irq_n  = irq_n_oe ? irq_n_o : 1'b1;

    modport dev  (input addr, wdata, io_write_strobe_n, io_read_strobe_n,
                  output rdata, rdata_oe, irq_n_o, irq_n_oe);
    modport host (output addr, wdata, io_write_strobe_n, io_read_strobe_n,
                  input bus_rd, irq_n);
endinterface : acg_io_if

// File: hdl/acg_dev.sv
// converter-side glue: strobe decode, status path, interrupt latch, clock divider
`timescale 1ns/1ns
module acg_dev (
    input  wire logic                core_clk,      // system clock
    input  wire logic                srst,          // sync reset
    acg_io_if.dev                    io,            // cpu i/o bus
    input  wire acg_pkg::acg_scheme_t scheme,       // decode scheme strap
    input  wire logic                irq_latch_en,  // use resettable latch
    output logic                     conv_ale,      // channel latch strobe
    output logic                     conv_start,    // start conversion
    output logic                     conv_oe,       // result output enable
    output logic [2:0]               conv_chan,     // channel select
    output logic                     conv_clk,      // divided converter clock
    input  wire logic                conv_eoc,      // conversion done pin
    input  wire logic [7:0]          conv_data      // converter result pins
);
    logic       wr;
    logic       rd;
    logic       sel_undec;
    logic       hit_ale;
    logic       hit_start;
    logic       hit_data;
    logic       hit_stat;
    logic [2:0] chan_src;
    logic [8:0] s1_reg;
    logic [8:0] s2_reg;
    logic [8:0] s3_reg;
    logic [8:0] pin_reg;
    logic       eoc;
    logic       eoc_prev_reg;
    logic       hit_data_prev_reg;
    logic       irq_latch_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_oe_reg;
    logic       ale_reg;
    logic       start_reg;
    logic       oe_reg;
    logic [2:0] chan_reg;
    logic       conv_clk_reg;
    logic [7:0] div_reg;

    // strobes are active low
    assign wr        = ~io.io_write_strobe_n;
    assign rd        = ~io.io_read_strobe_n;
    assign sel_undec = ~io.addr[acg_pkg::ACG_UNDEC_LINE];

    // port decode per scheme
    always_comb
    begin
        hit_ale   = 1'b0;
        hit_start = 1'b0;
        hit_data  = 1'b0;
        hit_stat  = 1'b0;
        chan_src  = io.addr[2:0];
        case (scheme)
            acg_pkg::ACG_UNDEC_DATA:
            begin
                hit_ale   = wr & sel_undec;
                hit_start = wr & sel_undec;
                hit_data  = rd & sel_undec;
                chan_src  = io.wdata[2:0];
            end
            acg_pkg::ACG_UNDEC_ADDR:
            begin
                hit_ale   = wr & sel_undec;
                hit_start = wr & sel_undec;
                hit_data  = rd & sel_undec;
            end
            acg_pkg::ACG_PARTIAL:
            begin
                hit_ale   = wr & (io.addr[7:6] == acg_pkg::ACG_TOP_ALE);
                hit_start = wr & (io.addr[7:6] == acg_pkg::ACG_TOP_START);
                hit_data  = rd & (io.addr[7:6] == acg_pkg::ACG_TOP_START);
                hit_stat  = rd & (io.addr[7:6] == acg_pkg::ACG_TOP_ALE);
            end
            default:
            begin
                hit_ale   = 1'b0;
            end
        endcase
    end

    // three-stage sync of converter pins; change taken when stages 2 and 3 agree
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            // done pin idles high; resetting to that level avoids a false edge
            s1_reg  <= 9'h100;
            s2_reg  <= 9'h100;
            s3_reg  <= 9'h100;
            pin_reg <= 9'h100;
        end
        else
        begin
            s1_reg <= {conv_eoc, conv_data};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < 9; i++)
            begin
                if (s2_reg[i] == s3_reg[i])
                    pin_reg[i] <= s3_reg[i];
            end
        end
    end

    assign eoc = pin_reg[8];

    // converter strobes follow the decoded cpu strobe
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ale_reg   <= 1'b0;
            start_reg <= 1'b0;
            oe_reg    <= 1'b0;
        end
        else
        begin
            ale_reg   <= hit_ale;    // converter takes channel on its rise
            start_reg <= hit_start;  // conversion begins on its fall
            oe_reg    <= hit_data;
        end
    end

    // channel register only moves during a channel selection
    always_ff @(posedge core_clk)
    begin
        if (srst)
            chan_reg <= 3'h0;
        else if (hit_ale)
            chan_reg <= chan_src;
    end

    // read data path: result on data read, done status on bit 0 only
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rdata_reg    <= 8'h00;
            rdata_oe_reg <= 8'h00;
        end
        else if (hit_data)
        begin
            rdata_reg    <= pin_reg[7:0];
            rdata_oe_reg <= 8'hFF;
        end
        else if (hit_stat)
        begin
            rdata_reg    <= {7'h00, ~eoc};                         // low means done
            rdata_oe_reg <= 8'h01;
        end
        else
        begin
            rdata_reg    <= 8'h00;
            rdata_oe_reg <= 8'h00;                                 // bus released
        end
    end

    // interrupt latch: set on done edge, cleared at start of a data read
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            eoc_prev_reg      <= 1'b1;
            hit_data_prev_reg <= 1'b0;
            irq_latch_reg     <= 1'b0;
        end
        else
        begin
            eoc_prev_reg      <= eoc;
            hit_data_prev_reg <= hit_data;
            if (eoc & ~eoc_prev_reg)
                irq_latch_reg <= 1'b1;                             // set beats clear
            else if (hit_data & ~hit_data_prev_reg)
                irq_latch_reg <= 1'b0;
        end
    end

    // converter clock divider
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            div_reg      <= 8'h00;
            conv_clk_reg <= 1'b0;
        end
        else if (div_reg == 8'(acg_pkg::ACG_CONV_HALF - 1))
        begin
            div_reg      <= 8'h00;
            conv_clk_reg <= ~conv_clk_reg;
        end
        else
        begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // outputs
    assign conv_ale    = ale_reg;
    assign conv_start  = start_reg;
    assign conv_oe     = oe_reg;
    assign conv_chan   = chan_reg;
    assign conv_clk    = conv_clk_reg;
    assign io.rdata    = rdata_reg;
    assign io.rdata_oe = rdata_oe_reg;
    // open-drain interrupt: latch or raw done, pulled low when asserted
    assign io.irq_n_o  = 1'b0;
    assign io.irq_n_oe = irq_latch_en ? irq_latch_reg : eoc;
endmodule : acg_dev

// File: tb/acg_assertions.sv
// concurrent checks on the cpu i/o bus joining the two glue ends
`timescale 1ns/1ns
module acg_assertions (
    input wire logic                 core_clk,          // system clock
    input wire logic                 srst,              // sync reset
    input wire logic [7:0]           addr,              // i/o address
    input wire logic [7:0]           wdata,             // host write data
    input wire logic [7:0]           rdata_oe,          // glue drive enables
    input wire logic [7:0]           bus_rd,            // resolved read bus
    input wire logic                 io_write_strobe_n, // write strobe
    input wire logic                 io_read_strobe_n,  // read strobe
    input wire logic                 irq_n_oe,          // interrupt pull
    input wire acg_pkg::acg_scheme_t scheme,            // decode scheme
    input wire logic                 irq_latch_en,      // latch mode
    input wire logic                 conv_ale,          // channel latch
    input wire logic                 conv_start,        // start strobe
    input wire logic                 conv_oe,           // output enable
    input wire logic [2:0]           conv_chan,         // channel select
    input wire logic                 conv_clk           // divided clock
);
    logic       wr;
    logic       rd;
    logic       pd;
    logic [1:0] top;
    logic       clk_q;
    logic       seen;
    logic [7:0] cnt;

    // decoded bus phases
    assign wr  = !io_write_strobe_n;
    assign rd  = !io_read_strobe_n;
    assign pd  = scheme == acg_pkg::ACG_PARTIAL;
    assign top = addr[7:6];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // length of the current converter clock level
    always_ff @(posedge core_clk)
    begin
        clk_q <= conv_clk;
        seen  <= !srst && (seen || conv_clk != clk_q);
        cnt   <= (srst || conv_clk != clk_q) ? 8'h00 : cnt + 8'h01;
    end

    AST_PD_START: assert property (pd && wr && top == 2'h0 |=> conv_start)
        else $error("start pulse missing");
    AST_PD_ALE: assert property (pd && wr && top == 2'h1 |=> conv_ale &&
        conv_chan == $past(addr[2:0])) else $error("latch pulse or channel wrong");
    AST_PD_READ: assert property (pd && rd && top == 2'h0 |=> conv_oe && !conv_start)
        else $error("data read without output enable");
    AST_STATUS: assert property (pd && rd && top == 2'h1 |=> rdata_oe == 8'h01 && !conv_oe)
        else $error("status read drives wrong bits");
    AST_UD_DATA: assert property (scheme == acg_pkg::ACG_UNDEC_DATA && wr && !addr[7]
        |=> conv_ale && conv_start && conv_chan == $past(wdata[2:0]))
        else $error("data-wired load wrong");
    AST_UD_ADDR: assert property (scheme == acg_pkg::ACG_UNDEC_ADDR && wr && !addr[7]
        |=> conv_ale && conv_start && conv_chan == $past(addr[2:0]))
        else $error("address-wired load wrong");
    AST_UD_READ: assert property (!pd && rd && !addr[7] |=> conv_oe && !conv_ale)
        else $error("undecoded read without output enable");
    AST_IDLE_BUS: assert property (!rd && !$past(rd) |-> rdata_oe == 8'h00 && bus_rd == 8'hFF)
        else $error("bus driven outside a read");
    AST_CHAN_HOLD: assert property (!$stable(conv_chan) |-> $past(wr))
        else $error("channel changed without a write");
    AST_IRQ_CLR: assert property (irq_latch_en && $stable(irq_latch_en) && $fell(irq_n_oe)
        |-> $past(rd) || $past(rd, 2)) else $error("interrupt latch cleared without read");
    AST_CLK_DIV: assert property (seen |-> cnt <= 8'(acg_pkg::ACG_CONV_HALF - 1) &&
        (conv_clk == clk_q || cnt == 8'(acg_pkg::ACG_CONV_HALF - 1)))
        else $error("converter clock period wrong");

    cover property (pd && rd && top == 2'h1);
    cover property (irq_latch_en && $fell(irq_n_oe));
    cover property (scheme == acg_pkg::ACG_UNDEC_ADDR && conv_start);
endmodule : acg_assertions

// File: tb/adc_cpu_port_decode_glue_tb.sv
// self-checking bench: wishbone host end facing the converter glue end
`timescale 1ns/1ns
module adc_cpu_port_decode_glue_tb;
    logic                 core_clk     = 1'b0;
    logic                 srst         = 1'b1;
    logic                 wb_cyc_i     = 1'b0;
    logic                 wb_stb_i     = 1'b0;
    logic                 wb_we_i      = 1'b0;
    logic [7:0]           wb_adr_i     = 8'h00;
    logic [3:0]           wb_sel_i     = 4'h0;
    logic [31:0]          wb_dat_i     = 32'h0;
    logic [31:0]          wb_dat_o;
    logic                 wb_ack_o;
    acg_pkg::acg_scheme_t scheme       = acg_pkg::ACG_UNDEC_DATA;
    logic                 irq_latch_en = 1'b0;
    logic                 conv_ale;
    logic                 conv_start;
    logic                 conv_oe;
    logic [2:0]           conv_chan;
    logic                 conv_clk;
    logic                 conv_eoc     = 1'b1;
    logic [7:0]           conv_data    = 8'hFF;
    logic [7:0]           res_tab [8];
    logic [2:0]           ch_lat       = 3'h0;
    logic                 start_q      = 1'b0;
    int                   busy_cnt     = 0;
    int                   conv_len     = 800;
    int                   n_mismatch   = 0;
    int                   checked      = 0;

    acg_io_if acg_io_if_inst ();
    acg_host acg_host_inst (.core_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .io(acg_io_if_inst));
    acg_dev acg_dev_inst (.core_clk, .srst, .io(acg_io_if_inst), .scheme, .irq_latch_en,
        .conv_ale, .conv_start, .conv_oe, .conv_chan, .conv_clk, .conv_eoc, .conv_data);
    acg_assertions acg_assertions_inst (.core_clk, .srst, .addr(acg_io_if_inst.addr),
        .wdata(acg_io_if_inst.wdata), .rdata_oe(acg_io_if_inst.rdata_oe),
        .bus_rd(acg_io_if_inst.bus_rd), .io_write_strobe_n(acg_io_if_inst.io_write_strobe_n),
        .io_read_strobe_n(acg_io_if_inst.io_read_strobe_n), .irq_n_oe(acg_io_if_inst.irq_n_oe),
        .scheme, .irq_latch_en, .conv_ale, .conv_start, .conv_oe, .conv_chan, .conv_clk);

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    // converter stand-in: restarts on falling start, result shown only under output enable
    always @(posedge core_clk)
    begin
        start_q <= conv_start;
        if (conv_ale) ch_lat <= conv_chan;
        // a restart during a conversion keeps done low, no new rising edge
        if (start_q && !conv_start)
            busy_cnt <= (busy_cnt > 0 && busy_cnt <= conv_len) ? conv_len : conv_len + 16;
        else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
        conv_eoc  <= busy_cnt == 0 || busy_cnt > conv_len;
        conv_data <= conv_oe ? res_tab[ch_lat] : ~res_tab[ch_lat];
    end

    // expected status word after a finished conversion
    function automatic logic [31:0] exp_status(input logic [2:0] ch);
        return {16'h0000, res_tab[ch], 8'h02};
    endfunction : exp_status

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one classic wishbone cycle, held until ack is seen
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            n_mismatch++;
            close_out;
        end
        // ack seen high at this edge: take data, then release
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    // one full conversion in the given scheme, optionally with a refused restart
    task automatic run(input acg_pkg::acg_scheme_t sch, input logic [2:0] ch,
                       input logic lat, input logic refuse);
        logic [31:0] q;
        int          k;
        scheme       <= sch;
        irq_latch_en <= lat;
        conv_len     <= 700 + int'($urandom % 500);
        res_tab[ch]  = 8'($urandom);
        wb(1'b1, acg_pkg::ACG_REG_CTRL, {25'h0, ch, sch, 1'b1}, q);
        if (refuse) wb(1'b1, acg_pkg::ACG_REG_CTRL, {25'h0, ~ch, sch, 1'b1}, q);
        wb(1'b0, acg_pkg::ACG_REG_CTRL, 32'h0, q);
        chk("ctrl", {25'h0, ch, sch, 1'b0}, q & 32'h7E);
        k = 0;
        do
        begin
            wb(1'b0, acg_pkg::ACG_REG_STATUS, 32'h0, q);
            k++;
        end
        while (q[0] !== 1'b0 && k < 3000);
        if (k >= 3000)
        begin
            n_mismatch++;
            close_out;
        end
        chk("status", exp_status(ch), q & 32'h0000FF03);
        wb(1'b1, acg_pkg::ACG_REG_STATUS, 32'h2, q);
        wb(1'b0, acg_pkg::ACG_REG_STATUS, 32'h0, q);
        chk("done clear", 32'h0, q & 32'h2);
        $display("conversion scheme %0d channel %0d finished", sch, ch);
    endtask : run

    // main sequence
    initial
    begin
        logic [31:0] q;
        void'($urandom(32'h97FD));
        foreach (res_tab[i]) res_tab[i] = 8'($urandom);
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        wb(1'b0, acg_pkg::ACG_REG_CTRL, 32'h0, q);
        chk("ctrl reset", 32'h2, q & 32'h7E);
        wb(1'b1, 8'h08, $urandom, q);
        wb(1'b0, 8'h08, 32'h0, q);
        chk("unmapped", 32'h0, q);
        $display("register reset and unmapped access test finished");
        for (int i = 0; i < 9; i++)
            run(i % 3 == 0 ? acg_pkg::ACG_UNDEC_DATA : i % 3 == 1 ? acg_pkg::ACG_UNDEC_ADDR :
                acg_pkg::ACG_PARTIAL, i == 0 ? 3'h0 : i == 8 ? 3'h7 : 3'($urandom),
                1'(i >> 1), i == 4);
        close_out;
    end
endmodule : adc_cpu_port_decode_glue_tb
